// ---- bench/aps_ctrl_tb.sv ----
/*
 Testbench of the pulse sequencer control: register access, run commands,
 pulse timing, section jumps, trigger sources and emit conditions.
 Assumes the package and the constants header are on the include path.
*/
`timescale 1ns/1ps
`include "aps_consts.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module aps_ctrl_tb;
   import aps_pkg::*;

   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   localparam logic [3:0] IDLE  = 4'ha;
   localparam int         LIMIT = 10000;
   logic          clk;
   logic          srst;
   aps_bus_req_t  bus;
   logic [31:0]   rdata;
   aps_trig_in_t  trig_in;
   logic [3:0]    control_out;
   logic [10:0]   want;
   logic [31:0]   d;
   int            len;
   int            bad_count;
   int            comparisons;
   int            cycles;
   logic [10:0]   pre_tab [0:15] = '{11'h3ff, 11'h5ff, 11'h6ff, 11'h77f, 11'h6ff, 11'h7bf, 11'h7df, 11'h7ef,
                                     11'h7f7, 11'h7fb, 11'h7fd, 11'h7ff, 11'h7fe, 11'h7ff, 11'h000, 11'h000};
   logic [10:0]   fin_tab [0:15] = '{11'h7ff, 11'h7ff, 11'h7ff, 11'h7ff, 11'h7ff, 11'h7ff, 11'h7ff, 11'h7ff,
                                     11'h7ff, 11'h7ff, 11'h7ff, 11'h7fd, 11'h7ff, 11'h7fe, 11'h7ff, 11'h7ff};

   aps_ctrl #(.UNIT_RATIO(4), .CAMERA_LINK(1'b1)) dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
                                                      .trig_in(trig_in), .control_out(control_out));
   aps_trig_src src (.clk(clk), .srst(srst), .want(want), .trig_in(trig_in));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic complete_run();
      $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rdc(input logic [31:0] exp);
      rd(`APS_OFS_CONTROL);
      `CHK(d, exp)
   endtask

   function automatic logic [31:0] cw(input logic [2:0] run, input logic [7:0] jmp, input logic [3:0] ts);
      return {ts, 4'h0, jmp, 8'h00, IDLE, 1'b0, run};
   endfunction

   task automatic ent(input logic [7:0] i, input logic sec, input logic fol, input logic [2:0] cond,
                      input logic [9:0] cnt, input logic [3:0] lvl, input logic [1:0] unit, input logic [7:0] nxt);
      wr(`APS_OFS_TBL_INDEX, {24'h0, i});
      wr(`APS_OFS_TBL_ENTRY, {sec, fol, cond, cnt, 1'b0, lvl, unit, 2'b00, nxt});
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Arms entry 9, holds the lines at pre, then moves them to fin
   task automatic fire(input logic [3:0] ts, input logic [2:0] cond, input logic [10:0] pre, fin,
                       input logic hit);
      @(posedge clk);
      want <= 11'h0;
      ent(8'd9, 1'b0, 1'b0, cond, 10'd0, 4'h3, 2'd0, 8'd0);
      @(posedge clk);
      want <= pre;
      wt(3);
      wr(`APS_OFS_CONTROL, cw(3'b001, 8'd9, ts));
      if (cond != 3'd0) begin
         rdc(cw(3'b001, 8'd9, ts));
      end
      @(posedge clk);
      want <= fin;
      wt(12);
      rdc(cw(hit ? 3'b000 : 3'b001, 8'd9, ts));
      wr(`APS_OFS_CONTROL, cw(3'b100, 8'd9, ts));
   endtask

   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      srst = 1'b1;
      bus = '0;
      want = '0;
      bad_count = 0;
      comparisons = 0;
      cycles = 0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rdc(32'h0);
      `CHK(control_out, 4'h0)
      rd(8'h0c);
      `CHK(d, 32'h0)
      wr(`APS_OFS_CONTROL, 32'hf05a00a0);
      rdc(32'hf05a00a0);
      wt(2);
      `CHK(control_out, IDLE)
      $display("test reset and fields done");
      for (int u = 0; u < 4; u++) begin
         ent(8'd3, 1'b0, 1'b0, 3'd0, 10'd2, 4'h5, u[1:0], 8'd0);
         wr(`APS_OFS_CONTROL, cw(3'b001, 8'd3, 4'h0));
         len = 20 * (4 ** u) + 1;
         wt(len + 1);
         `CHK(control_out, 4'h5)
         wt(1);
         `CHK(control_out, IDLE)
         rdc(cw(3'b000, 8'd3, 4'h0));
      end
      $display("test pulse units done");
      ent(8'd3, 1'b1, 1'b1, 3'd0, 10'd3, 4'h5, 2'd0, 8'd3);
      ent(8'd7, 1'b0, 1'b1, 3'd0, 10'd1, 4'hc, 2'd0, 8'd7);
      wr(`APS_OFS_CONTROL, cw(3'b001, 8'd3, 4'h0));
      wr(`APS_OFS_CONTROL, cw(3'b010, 8'd7, 4'h0));
      wt(12);
      `CHK(control_out, 4'h5)
      wt(30);
      `CHK(control_out, 4'hc)
      rdc(cw(3'b001, 8'd7, 4'h0));
      wr(`APS_OFS_CONTROL, cw(3'b010, 8'd3, 4'h0));
      wt(40);
      `CHK(control_out, 4'hc)
      wr(`APS_OFS_CONTROL, cw(3'b011, 8'd3, 4'h0));
      wt(40);
      `CHK(control_out, 4'hc)
      rdc(cw(3'b011, 8'd3, 4'h0));
      wr(`APS_OFS_CONTROL, cw(3'b101, 8'd3, 4'h0));
      rdc(cw(3'b011, 8'd3, 4'h0));
      wr(`APS_OFS_CONTROL, cw(3'b100, 8'd3, 4'h0));
      rdc(cw(3'b000, 8'd3, 4'h0));
      `CHK(control_out, IDLE)
      wr(`APS_OFS_CONTROL, cw(3'b001, 8'd3, 4'h0));
      wr(`APS_OFS_CONTROL, cw(3'b011, 8'd3, 4'h0));
      wt(40);
      rdc(cw(3'b000, 8'd3, 4'h0));
      `CHK(control_out, IDLE)
      wr(`APS_OFS_CONTROL, cw(3'b001, 8'd3, 4'h0));
      wr(`APS_OFS_CONTROL, cw(3'b000, 8'd3, 4'h0));
      rdc(cw(3'b000, 8'd3, 4'h0));
      `CHK(control_out, IDLE)
      $display("test sections done");
      for (int c = 0; c < 16; c++) begin
         fire(c[3:0], 3'd1, pre_tab[c], fin_tab[c], c < 14);
      end
      $display("test trigger sources done");
      for (int c = 0; c < 6; c++) begin
         fire(4'h0, c[2:0], (c == 2 || c == 4) ? 11'h400 : 11'h000,
              (c == 2 || c == 4) ? 11'h000 : 11'h400, 1'b1);
      end
      $display("test emit conditions done");
      complete_run();
   end
endmodule

// ---- bench/aps_trig_src.sv ----
/*
 Far-side model of the pulse sequencer control block: the trigger, encoder
 and video-timing lines, registered on clk as the design expects.
 Assumes the bench sets the wanted line pattern just after a rising edge.
*/
`timescale 1ns/1ps

module aps_trig_src (
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic [10:0]           want,
   output aps_pkg::aps_trig_in_t      trig_in
);
   import aps_pkg::*;

   // -----------------------------------------------------------------
   // Line drivers
   // -----------------------------------------------------------------
   // Levels change only at a clock edge, synchronous to the design
   always_ff @(posedge clk) begin
      if (srst) begin
         trig_in <= '0;
      end else begin
         trig_in <= want;
      end
   end
endmodule

// ---- hdl/aps_consts.svh ----
/*
 Constants of the auxiliary pulse sequencer control block: register offsets,
 control field positions, reset values and timing counts.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef APS_CONSTS_SVH
`define APS_CONSTS_SVH

// -----------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------
`define APS_OFS_CONTROL     8'h00
`define APS_OFS_TBL_INDEX   8'h04
`define APS_OFS_TBL_ENTRY   8'h08

// -----------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------
`define APS_CTL_RUN_LSB     0
`define APS_CTL_RUN_W       3
`define APS_CTL_IDLE_LSB    4
`define APS_LINES           4
`define APS_CTL_JUMP_LSB    16
`define APS_IDX_W           8
`define APS_CTL_TSEL_LSB    28
`define APS_TSEL_W          4
`define APS_COUNT_W         10
`define APS_TABLE_DEPTH     256

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define APS_RST_IDLE_LEVEL  4'h0
`define APS_RST_JUMP_INDEX  8'h00
`define APS_RST_TSEL        4'h0
`define APS_RST_TBL_INDEX   8'h00

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define APS_CLK_PERIOD_NS   10
`define APS_UNIT_BASE_NS    100
`define APS_BASE_CYC        (`APS_UNIT_BASE_NS / `APS_CLK_PERIOD_NS)
`define APS_UNIT_RATIO      1000

`endif

// ---- hdl/aps_ctrl.sv ----
/*
 Auxiliary pulse sequencer control: control register, trigger source mux,
 pulse table walker and the four control output lines.
 Assumes a synchronous register master, inputs synchronous to clk.
*/
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "aps_consts.svh"

module aps_ctrl #(
   parameter int UNIT_RATIO  = `APS_UNIT_RATIO,
   parameter bit CAMERA_LINK = 1'b1
) (
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire aps_pkg::aps_bus_req_t bus,
   output logic [31:0]               rdata,
   input  wire aps_pkg::aps_trig_in_t trig_in,
   output logic [`APS_LINES-1:0]     control_out
);
   import aps_pkg::*;

   // --------------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------------
   localparam int RW = $clog2(UNIT_RATIO);
   localparam logic [RW-1:0] RATIO_M1 = RW'(UNIT_RATIO - 1);
   localparam logic [3:0]    BASE_M1  = 4'(`APS_BASE_CYC - 1);

   aps_run_t                  run_cmd;
   aps_state_t                st;
   logic [`APS_LINES-1:0]     idle_level;
   logic [`APS_IDX_W-1:0]     jump_index;
   logic [`APS_TSEL_W-1:0]    trig_sel;
   logic [`APS_IDX_W-1:0]     tbl_index;
   aps_entry_t                table_mem [0:`APS_TABLE_DEPTH-1];
   logic [`APS_IDX_W-1:0]     idx;
   aps_entry_t                cur;
   logic                      trig;
   logic                      trig_prev;
   logic                      fval_prev;
   logic                      lval_prev;
   logic [`APS_COUNT_W-1:0]   units_left;
   logic [3:0]                base_cnt;
   logic [3:0]                tick;
   logic                      unit_tick;
   logic                      pulse_done;
   logic                      cond_met;
   logic                      ctl_wr;
   logic                      cmd_valid;
   aps_run_t                  wr_cmd;

   assign ctl_wr    = bus.wr && (bus.addr == `APS_OFS_CONTROL);
   assign wr_cmd    = aps_run_t'(bus.wdata[`APS_CTL_RUN_LSB +: `APS_CTL_RUN_W]);
   assign cmd_valid = bus.wdata[`APS_CTL_RUN_LSB +: `APS_CTL_RUN_W] <= APS_RUN_ABORT;
   assign cur       = table_mem[idx];

   // --------------------------------------------------------------------
   // Trigger source selection
   // --------------------------------------------------------------------
   function automatic logic sel_src(input logic [3:0] s, input aps_trig_in_t t,
                                    input logic fp, input logic lp);
      logic cl;
      cl = CAMERA_LINK;
      case (s)
         4'h0: sel_src = t.channel_chosen_trigger;
         4'h1: sel_src = t.channel_encoder_a;
         4'h2: sel_src = t.channel_encoder_b;
         4'h3: sel_src = t.channel_quadrature_output;
         4'h4: sel_src = t.channel_chosen_trigger & t.channel_encoder_b;
         4'h5: sel_src = t.channel_encoder_divider_out;
         4'h6: sel_src = t.frame_start;
         4'h7: sel_src = t.frame_end;
         4'h8: sel_src = t.line_start;
         4'h9: sel_src = t.line_end;
         4'ha: sel_src = cl & t.fval & ~fp;
         4'hb: sel_src = cl & ~t.fval & fp;
         4'hc: sel_src = cl & t.lval & ~lp;
         4'hd: sel_src = cl & ~t.lval & lp;
         default: sel_src = 1'b0;
      endcase
   endfunction

   function automatic logic cond_ok(input logic [2:0] c, input logic t, input logic tp);
      case (c)
         APS_COND_NOW:  cond_ok = 1'b1;
         APS_COND_RISE: cond_ok = t & ~tp;
         APS_COND_FALL: cond_ok = ~t & tp;
         APS_COND_HIGH: cond_ok = t;
         APS_COND_LOW:  cond_ok = ~t;
         APS_COND_BOTH: cond_ok = t ^ tp;
         default:       cond_ok = 1'b0;
      endcase
   endfunction

   assign trig = sel_src(trig_sel, trig_in, fval_prev, lval_prev);
   assign cond_met = cond_ok(cur.pulse_emit_condition, trig, trig_prev);

   always_ff @(posedge clk) begin
      if (srst) begin
         trig_prev <= 1'b0;
         fval_prev <= 1'b0;
         lval_prev <= 1'b0;
      end else begin
         trig_prev <= trig;
         fval_prev <= trig_in.fval;
         lval_prev <= trig_in.lval;
      end
   end

   // --------------------------------------------------------------------
   // Register file
   // --------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         idle_level <= `APS_RST_IDLE_LEVEL;
         jump_index <= `APS_RST_JUMP_INDEX;
         trig_sel   <= `APS_RST_TSEL;
         tbl_index  <= `APS_RST_TBL_INDEX;
      end else if (bus.wr) begin
         if (bus.addr == `APS_OFS_CONTROL) begin
            idle_level <= bus.wdata[`APS_CTL_IDLE_LSB +: `APS_LINES];
            jump_index <= bus.wdata[`APS_CTL_JUMP_LSB +: `APS_IDX_W];
            trig_sel   <= bus.wdata[`APS_CTL_TSEL_LSB +: `APS_TSEL_W];
         end
         if (bus.addr == `APS_OFS_TBL_INDEX) begin
            tbl_index <= bus.wdata[`APS_IDX_W-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (bus.wr && (bus.addr == `APS_OFS_TBL_ENTRY)) begin
         table_mem[tbl_index] <= bus.wdata;
      end
   end

   // Read data valid in the cycle after the strobe only
   always_ff @(posedge clk) begin
      if (srst || !bus.rd) begin
         rdata <= 32'h0000_0000;
      end else begin
         case (bus.addr)
            `APS_OFS_CONTROL:   rdata <= {trig_sel, 4'h0, jump_index, 8'h00, idle_level, 1'b0, run_cmd};
            `APS_OFS_TBL_INDEX: rdata <= {24'h00_0000, tbl_index};
            `APS_OFS_TBL_ENTRY: rdata <= table_mem[tbl_index];
            default:            rdata <= 32'h0000_0000;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // Sequencer
   // --------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         st      <= APS_ST_IDLE;
         run_cmd <= APS_RUN_IDLE;
         idx     <= `APS_RST_JUMP_INDEX;
      end else if (ctl_wr && cmd_valid && (wr_cmd == APS_RUN_GO)) begin
         st      <= APS_ST_WAIT;
         run_cmd <= APS_RUN_GO;
         idx     <= bus.wdata[`APS_CTL_JUMP_LSB +: `APS_IDX_W];
      end else if (ctl_wr && cmd_valid && ((wr_cmd == APS_RUN_ABORT) || (wr_cmd == APS_RUN_IDLE))) begin
         st      <= APS_ST_IDLE;
         run_cmd <= APS_RUN_IDLE;
      end else if (ctl_wr && cmd_valid && (st != APS_ST_IDLE)) begin
         run_cmd <= wr_cmd;
      end else begin
         case (st)
            APS_ST_IDLE: begin
               run_cmd <= APS_RUN_IDLE;
            end
            APS_ST_WAIT: begin
               if (cond_met) begin
                  st <= APS_ST_PULSE;
               end
            end
            APS_ST_PULSE: begin
               if (pulse_done) begin
                  if ((run_cmd == APS_RUN_JUMP) && cur.section_end_flag) begin
                     idx     <= jump_index;
                     run_cmd <= APS_RUN_GO;
                     st      <= APS_ST_WAIT;
                  end else if (((run_cmd == APS_RUN_STOP) && cur.section_end_flag) || !cur.follow_next) begin
                     st      <= APS_ST_IDLE;
                     run_cmd <= APS_RUN_IDLE;
                  end else begin
                     idx <= cur.next_index;
                     st  <= APS_ST_WAIT;
                  end
               end
            end
            default: begin
               st      <= APS_ST_IDLE;
               run_cmd <= APS_RUN_IDLE;
            end
         endcase
      end
   end

   // --------------------------------------------------------------------
   // Pulse timing
   // --------------------------------------------------------------------
   // unit prescaler chain
   always_ff @(posedge clk) begin
      if (srst || (st != APS_ST_PULSE) || (base_cnt == BASE_M1)) begin
         base_cnt <= 4'h0;
      end else begin
         base_cnt <= base_cnt + 4'h1;
      end
   end
   assign tick[0] = (st == APS_ST_PULSE) && (base_cnt == BASE_M1);

   genvar g;
   generate
      for (g = 1; g < 4; g++) begin : g_dec
         logic [RW-1:0] cnt;
         always_ff @(posedge clk) begin
            if (srst || (st != APS_ST_PULSE)) begin
               cnt <= '0;
            end else if (tick[g-1]) begin
               cnt <= (cnt == RATIO_M1) ? '0 : cnt + 1'b1;
            end
         end
         assign tick[g] = tick[g-1] && (cnt == RATIO_M1);
      end
   endgenerate

   assign unit_tick  = tick[cur.pulse_time_unit];
   assign pulse_done = (st == APS_ST_PULSE) && (units_left == '0);

   always_ff @(posedge clk) begin
      if (srst) begin
         units_left <= '0;
      end else if (st != APS_ST_PULSE) begin
         units_left <= cur.pulse_length_count;
      end else if (unit_tick && (units_left != '0)) begin
         units_left <= units_left - 1'b1;
      end
   end

   // --------------------------------------------------------------------
   // Output lines
   // --------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         control_out <= `APS_RST_IDLE_LEVEL;
      end else begin
         case (st)
            APS_ST_IDLE:  control_out <= idle_level;
            APS_ST_PULSE: control_out <= cur.entry_level;
            default:      control_out <= control_out;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_idle_state;
      run_cmd == APS_RUN_IDLE |-> st == APS_ST_IDLE;
   endproperty
   a_idle_state: assert property (p_idle_state) else $error("idle command but sequencer active");

   property p_run_start;
      ctl_wr && (wr_cmd == APS_RUN_GO)
         |=> (st == APS_ST_WAIT) && (idx == $past(bus.wdata[23:16])) && (run_cmd == APS_RUN_GO);
   endproperty
   a_run_start: assert property (p_run_start) else $error("run did not start at jump index");

   property p_jump_sync;
      pulse_done && !ctl_wr && (run_cmd == APS_RUN_JUMP) && cur.section_end_flag
         |=> (idx == $past(jump_index)) && (run_cmd == APS_RUN_GO) && (st == APS_ST_WAIT);
   endproperty
   a_jump_sync: assert property (p_jump_sync) else $error("jump not taken at section end");

   property p_stop_end;
      pulse_done && !ctl_wr && (run_cmd == APS_RUN_STOP) && cur.section_end_flag
         |=> (st == APS_ST_IDLE) && (run_cmd == APS_RUN_IDLE);
   endproperty
   a_stop_end: assert property (p_stop_end) else $error("stop did not halt at section end");

   property p_abort;
      ctl_wr && (wr_cmd == APS_RUN_ABORT) |=> (st == APS_ST_IDLE) && (run_cmd == APS_RUN_IDLE);
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not halt at once");

   property p_no_early_jump;
      (st == APS_ST_PULSE) && !pulse_done && !ctl_wr |=> $stable(idx);
   endproperty
   a_no_early_jump: assert property (p_no_early_jump) else $error("index moved mid pulse");

   property p_readback;
      bus.rd && (bus.addr == `APS_OFS_CONTROL) |=> rdata[2:0] == $past(run_cmd);
   endproperty
   a_readback: assert property (p_readback) else $error("run command readback wrong");

   property p_idle_out;
      (st == APS_ST_IDLE) [*2] |-> control_out == $past(idle_level);
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("idle level not driven");

   property p_gated;
      trig_sel == 4'h4 |-> trig == (trig_in.channel_chosen_trigger & trig_in.channel_encoder_b);
   endproperty
   a_gated: assert property (p_gated) else $error("gated trigger wrong");

   property p_reserved_cmd;
      ctl_wr && !cmd_valid && !pulse_done |=> run_cmd == $past(run_cmd);
   endproperty
   a_reserved_cmd: assert property (p_reserved_cmd) else $error("reserved command changed state");

   property p_pulse_out;
      (st == APS_ST_PULSE) |=> control_out == $past(cur.entry_level);
   endproperty
   a_pulse_out: assert property (p_pulse_out) else $error("entry levels not driven");

endmodule

// ---- hdl/aps_pkg.sv ----
/*
 Types of the auxiliary pulse sequencer control block.
 Assumes the constants header is on the include path.
*/
package aps_pkg;
`include "aps_consts.svh"

   // --------------------------------------------------------------------
   // Enumerations
   // --------------------------------------------------------------------
   typedef enum logic [2:0] {
      APS_RUN_IDLE  = 3'b000,
      APS_RUN_GO    = 3'b001,
      APS_RUN_JUMP  = 3'b010,
      APS_RUN_STOP  = 3'b011,
      APS_RUN_ABORT = 3'b100
   } aps_run_t;

   typedef enum logic [1:0] {
      APS_ST_IDLE  = 2'b00,
      APS_ST_WAIT  = 2'b01,
      APS_ST_PULSE = 2'b10
   } aps_state_t;

   typedef enum logic [2:0] {
      APS_COND_NOW  = 3'b000,
      APS_COND_RISE = 3'b001,
      APS_COND_FALL = 3'b010,
      APS_COND_HIGH = 3'b011,
      APS_COND_LOW  = 3'b100,
      APS_COND_BOTH = 3'b101
   } aps_cond_t;

   // --------------------------------------------------------------------
   // Carriers
   // --------------------------------------------------------------------
   typedef struct packed {
      logic section_end_flag;
      logic follow_next;
      logic [2:0] pulse_emit_condition;
      logic [`APS_COUNT_W-1:0] pulse_length_count;
      logic rsv_hi;
      logic [`APS_LINES-1:0] entry_level;
      logic [1:0] pulse_time_unit;
      logic [1:0] rsv_lo;
      logic [`APS_IDX_W-1:0] next_index;
   } aps_entry_t;

   typedef struct packed {
      logic channel_chosen_trigger;
      logic channel_encoder_a;
      logic channel_encoder_b;
      logic channel_quadrature_output;
      logic channel_encoder_divider_out;
      logic frame_start;
      logic frame_end;
      logic line_start;
      logic line_end;
      logic fval;
      logic lval;
   } aps_trig_in_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } aps_bus_req_t;

endpackage
